// ===== include/lst_pkg.sv
package lst_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] LST_OFS_CTRL = 8'h00;
  localparam logic [7:0] LST_OFS_THR_HI = 8'h04;
  localparam logic [7:0] LST_OFS_THR_LO = 8'h08;
  localparam logic [7:0] LST_OFS_FLAGS = 8'h0c;
  localparam logic [7:0] LST_OFS_HIST0 = 8'h10;
  localparam logic [7:0] LST_OFS_HIST1 = 8'h14;
  localparam logic [7:0] LST_OFS_HIST2 = 8'h18;
  localparam logic [7:0] LST_OFS_HIST3 = 8'h1c;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int LST_CTRL_MODE_LSB = 0;
  localparam int LST_CTRL_QUICK_WAKE = 2;
  localparam int LST_CTRL_PIN_DIR = 3;
  localparam int LST_CTRL_POL = 4;
  localparam int LST_CTRL_LATCH = 5;
  localparam int LST_CTRL_PFUNC_LSB = 6;
  localparam int LST_CTRL_FCNT_LSB = 8;

  // Flags register fields
  localparam int LST_FLG_HI = 0;
  localparam int LST_FLG_LO = 1;
  localparam int LST_FLG_BUSY = 2;
  localparam int LST_FLG_POWERED = 3;
  localparam int LST_FLG_FILL_LSB = 4;

  // ---------------------------------------------------------------
  // Encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] LST_MODE_OFF = 2'h0;
  localparam logic [1:0] LST_MODE_FORCED = 2'h1;
  localparam logic [1:0] LST_MODE_REGULAR = 2'h2;
  localparam logic [1:0] LST_MODE_CONT = 2'h3;
  localparam logic [1:0] LST_PF_FAULT = 2'h0;
  localparam logic [1:0] LST_PF_EACH = 2'h1;
  localparam logic [1:0] LST_PF_FULL = 2'h3;
  localparam logic [27:0] LST_THR_HI_RST = 28'hfffffff;
  localparam logic [27:0] LST_THR_LO_RST = 28'h0000000;
  localparam int LST_RES_W = 28;
  localparam int LST_HIST_DEPTH = 4;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int LST_CLK_NS = 20;
  localparam int LST_PULSE_NS = 1000;
  localparam int LST_PULSE_CYC = LST_PULSE_NS / LST_CLK_NS;
  localparam int LST_RANGE_RST_NS = 500000;
  localparam int LST_RANGE_RST_CYC = (LST_RANGE_RST_NS + LST_CLK_NS - 1) / LST_CLK_NS;

  // Sequencer states
  typedef enum logic [1:0] {
    LST_ST_IDLE = 2'b00,
    LST_ST_RANGE = 2'b01,
    LST_ST_CONV = 2'b10
  } lst_state_t;

endpackage

// ===== include/lst_flt_if.sv
`timescale 1ns/1ps
`default_nettype none
// Fault qualification handshake between sequencer and counter
interface lst_flt_if;
  logic sample;
  logic fault;
  logic [3:0] need;
  logic qual;
  modport seq (output sample, output fault, output need, input qual);
  modport cnt (input sample, input fault, input need, output qual);
endinterface
`default_nettype wire

// ===== rtl/lst_fault_qual.sv
`timescale 1ns/1ps
`default_nettype none
module lst_fault_qual (
  input wire logic pclk,
  input wire logic presetn,
  lst_flt_if.cnt flt
);

  typedef struct packed {
    logic [3:0] run;
  } lst_fq_t;

  lst_fq_t st_reg;
  lst_fq_t st_next;

  // Count consecutive faults; any clean sample restarts the run
  always_comb begin
    st_next = st_reg;
    if (flt.sample) begin
      if (!flt.fault) begin
        st_next.run = 4'h0;
      end else if (st_reg.run != 4'hf) begin
        st_next.run = st_reg.run + 4'h1;
      end
    end
  end

  // Qualifies once the run is at most one short; no wrap at saturation
  assign flt.qual = flt.sample & flt.fault & (st_reg.run >= (flt.need - 4'h1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule // lst_fault_qual
`default_nettype wire

// ===== rtl/lst_trigger_alert.sv
// Contract
// (R1) Pin input mode: pin edge starts measurement
// (R2) Trigger-input pin gives no completion signal
// (R3) Writing mode 1 or 2 starts one measurement
// (R4) Mode field self-clears after register-triggered measurement
// (R5) Output pin signals completion of register conversions
// (R6) Triggers ignored while a conversion runs
// (R7) Standby after single shot unless quick wake
// (R8) Host times pin-triggered conversions itself
// (R9) Host spaces triggers to cover all delays
// (R10) Pin is open drain, pulls only
// (R11) Pin active level follows polarity setting
// (R12) Hysteresis: pin set high, cleared low
// (R13) Hysteresis flags set/cleared, held between limits
// (R14) Window mode: pin and flags on faults
// (R15) Window mode: reading 0x0C clears flags, pin
// (R16) Change needs 2^field consecutive faults
// (R17) Flags keep comparing whatever pin function
// (R18) Pin function 1: 1us pulse per conversion
// (R19) Pin function 3: pulse every 4 conversions
// (R20) Forced mode resets range logic 500us first
// (R21) Continuous mode converts back to back, pulses
// (R22) Four-deep result history, oldest discarded
// (R23) Reset: pin inactive, flags cleared
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module lst_trigger_alert
  import lst_pkg::*;
#(
  parameter int RANGE_RST_CYC = LST_RANGE_RST_CYC,
  parameter int PULSE_CYC = LST_PULSE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic alert_in,
  output logic alert_out,
  output logic alert_oe_n,
  output logic meas_start,
  output logic meas_range_reset,
  output logic meas_powered,
  input wire logic meas_done,
  input wire logic [27:0] meas_result
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (RANGE_RST_CYC < 1 || RANGE_RST_CYC > 65535) begin : g_chk_rr
    $error("RANGE_RST_CYC out of range 1..65535");
  end
  if (PULSE_CYC < 1 || PULSE_CYC > 255) begin : g_chk_pw
    $error("PULSE_CYC out of range 1..255");
  end

  // Range wait counts down through zero, so load one less
  localparam logic [15:0] RR_LOAD = 16'(RANGE_RST_CYC - 1);
  localparam logic [7:0] PW_LOAD = 8'(PULSE_CYC);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    lst_state_t st;
    logic [1:0] op_mode;
    logic quick_wake;
    logic pin_dir;
    logic alert_polarity;
    logic latch;
    logic [1:0] pin_func;
    logic [1:0] fcount;
    logic [27:0] thr_hi;
    logic [27:0] thr_lo;
    logic flag_hi;
    logic flag_lo;
    logic thr_pin;
    logic [LST_HIST_DEPTH-1:0][27:0] hist;
    logic [1:0] fill;
    logic [7:0] pulse_cnt;
    logic [15:0] wait_cnt;
    logic reg_trig;
    logic start;
    logic [2:0] sync;
    logic oe_n;
    logic [31:0] rdata;
  } lst_regs_t;

  // All state but the fault-run counters in one register; next value built below
  lst_regs_t r_reg;
  lst_regs_t r_next;

  // One consecutive-fault counter per limit
  lst_flt_if flt_hi ();
  lst_flt_if flt_lo ();

  // Bus decode and comparator helpers
  logic wr_acc;
  logic rd_acc;
  logic mapped;
  logic pin_edge;
  logic done_ok;
  logic pin_active;
  logic [3:0] need;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  // Zero wait states: every access phase completes at once
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= LST_OFS_HIST3);
  assign wr_acc = psel & penable & pwrite & mapped;
  assign rd_acc = psel & penable & ~pwrite & mapped;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = r_reg.rdata;

  // ---------------------------------------------------------------
  // Fault qualification
  // ---------------------------------------------------------------
  assign done_ok = (r_reg.st == LST_ST_CONV) & meas_done;
  assign need = 4'h1 << r_reg.fcount; // [R16]

  // Raw codes compared; equal to a limit is not a fault
  assign flt_hi.sample = done_ok;
  assign flt_hi.fault = meas_result > r_reg.thr_hi;
  assign flt_hi.need = need;
  assign flt_lo.sample = done_ok;
  assign flt_lo.fault = meas_result < r_reg.thr_lo;
  assign flt_lo.need = need;

  lst_fault_qual u_qual_hi (
    .pclk(pclk),
    .presetn(presetn),
    .flt(flt_hi.cnt)
  );

  lst_fault_qual u_qual_lo (
    .pclk(pclk),
    .presetn(presetn),
    .flt(flt_lo.cnt)
  );

  // ---------------------------------------------------------------
  // Pin sampling
  // ---------------------------------------------------------------
  // Edge toward the active level, seen only past the second flop
  assign pin_edge = r_reg.alert_polarity ? (r_reg.sync[1] & ~r_reg.sync[2])
                                         : (~r_reg.sync[1] & r_reg.sync[2]);

  // Pin function decides what is shown; input mode shows nothing
  always_comb begin
    pin_active = 1'b0;
    if (r_reg.pin_dir) begin
      case (r_reg.pin_func)
        LST_PF_FAULT: pin_active = r_reg.thr_pin; // [R12] [R14]
        LST_PF_EACH: pin_active = (r_reg.pulse_cnt != 8'h00); // [R18] [R5]
        LST_PF_FULL: pin_active = (r_reg.pulse_cnt != 8'h00); // [R19]
        default: pin_active = 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    // Start is a one-cycle strobe; pin history shifts every cycle
    r_next.start = 1'b0;
    r_next.sync = {r_reg.sync[1:0], alert_in};

    // Pulse timer runs down whatever the pin setting
    if (r_reg.pulse_cnt != 8'h00) begin
      r_next.pulse_cnt = r_reg.pulse_cnt - 8'h01;
    end

    // Register writes
    if (wr_acc) begin
      case (paddr)
        LST_OFS_CTRL: begin
          // Mode field is frozen while busy so a late trigger is dropped
          if (r_reg.st == LST_ST_IDLE) begin // [R6]
            r_next.op_mode = pwdata[LST_CTRL_MODE_LSB +: 2];
            r_next.reg_trig = (pwdata[LST_CTRL_MODE_LSB +: 2] == LST_MODE_FORCED) ||
                              (pwdata[LST_CTRL_MODE_LSB +: 2] == LST_MODE_REGULAR); // [R3]
          end
          r_next.quick_wake = pwdata[LST_CTRL_QUICK_WAKE];
          r_next.pin_dir = pwdata[LST_CTRL_PIN_DIR];
          r_next.alert_polarity = pwdata[LST_CTRL_POL];
          r_next.latch = pwdata[LST_CTRL_LATCH];
          r_next.pin_func = pwdata[LST_CTRL_PFUNC_LSB +: 2];
          r_next.fcount = pwdata[LST_CTRL_FCNT_LSB +: 2];
        end
        LST_OFS_THR_HI: r_next.thr_hi = pwdata[27:0];
        LST_OFS_THR_LO: r_next.thr_lo = pwdata[27:0];
        default: r_next.thr_lo = r_next.thr_lo;
      endcase
    end

    // Reading flags clears latched state; a new fault below wins
    if (rd_acc && paddr == LST_OFS_FLAGS && r_reg.latch) begin
      r_next.flag_hi = 1'b0; // [R15]
      r_next.flag_lo = 1'b0;
      r_next.thr_pin = 1'b0;
    end

    // Sequencer
    case (r_reg.st)
      LST_ST_IDLE: begin
        // Register trigger first, then continuous, then pin edge
        if (r_next.reg_trig && r_next.op_mode == LST_MODE_FORCED) begin
          r_next.st = LST_ST_RANGE; // [R20]
          r_next.wait_cnt = RR_LOAD;
        end else if (r_next.reg_trig || r_reg.op_mode == LST_MODE_CONT) begin // [R3] [R21]
          r_next.st = LST_ST_CONV;
          r_next.start = 1'b1;
        end else if (!r_reg.pin_dir && pin_edge) begin // [R1]
          r_next.st = LST_ST_CONV;
          r_next.start = 1'b1;
        end
      end
      LST_ST_RANGE: begin
        // Range logic held in reset for the full interval
        if (r_reg.wait_cnt == 16'h0000) begin
          r_next.st = LST_ST_CONV;
          r_next.start = 1'b1;
        end else begin
          r_next.wait_cnt = r_reg.wait_cnt - 16'h0001; // [R20]
        end
      end
      LST_ST_CONV: begin
        if (meas_done) begin
          r_next.st = LST_ST_IDLE; // [R7]
          // Newest result enters slot zero, oldest drops out
          r_next.hist = {r_reg.hist[LST_HIST_DEPTH-2:0], meas_result}; // [R22]
          r_next.fill = r_reg.fill + 2'h1;
          if (r_reg.reg_trig) begin
            r_next.op_mode = LST_MODE_OFF; // [R4]
            r_next.reg_trig = 1'b0;
          end
          // Completion pulse; never seen while the pin is an input
          if (r_reg.pin_func == LST_PF_EACH ||
              (r_reg.pin_func == LST_PF_FULL && r_reg.fill == 2'h3)) begin // [R18] [R19] [R21]
            r_next.pulse_cnt = PW_LOAD;
          end
          // Threshold flags run under every pin function
          if (r_reg.latch) begin
            if (flt_hi.qual) begin
              r_next.flag_hi = 1'b1; // [R14] [R17]
              r_next.thr_pin = 1'b1;
            end
            if (flt_lo.qual) begin
              r_next.flag_lo = 1'b1; // [R14]
              r_next.thr_pin = 1'b1;
            end
          end else begin
            if (flt_hi.qual) begin
              r_next.flag_hi = 1'b1; // [R13] [R12]
              r_next.flag_lo = 1'b0;
              r_next.thr_pin = 1'b1;
            end else if (flt_lo.qual) begin
              r_next.flag_hi = 1'b0; // [R13] [R12]
              r_next.flag_lo = 1'b1;
              r_next.thr_pin = 1'b0;
            end
          end
        end
      end
      default: r_next.st = LST_ST_IDLE;
    endcase

    // Open drain: pull low only; active-high level comes from pull-up
    r_next.oe_n = ~(r_reg.pin_dir & (r_reg.alert_polarity ? ~pin_active : pin_active)); // [R10] [R11] [R2]

    // Read data is captured in the setup phase
    r_next.rdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        LST_OFS_CTRL: begin
          r_next.rdata[LST_CTRL_MODE_LSB +: 2] = r_reg.op_mode;
          r_next.rdata[LST_CTRL_QUICK_WAKE] = r_reg.quick_wake;
          r_next.rdata[LST_CTRL_PIN_DIR] = r_reg.pin_dir;
          r_next.rdata[LST_CTRL_POL] = r_reg.alert_polarity;
          r_next.rdata[LST_CTRL_LATCH] = r_reg.latch;
          r_next.rdata[LST_CTRL_PFUNC_LSB +: 2] = r_reg.pin_func;
          r_next.rdata[LST_CTRL_FCNT_LSB +: 2] = r_reg.fcount;
        end
        LST_OFS_THR_HI: r_next.rdata[27:0] = r_reg.thr_hi;
        LST_OFS_THR_LO: r_next.rdata[27:0] = r_reg.thr_lo;
        LST_OFS_FLAGS: begin
          r_next.rdata[LST_FLG_HI] = r_reg.flag_hi;
          r_next.rdata[LST_FLG_LO] = r_reg.flag_lo;
          r_next.rdata[LST_FLG_BUSY] = (r_reg.st != LST_ST_IDLE);
          r_next.rdata[LST_FLG_POWERED] = meas_powered;
          r_next.rdata[LST_FLG_FILL_LSB +: 2] = r_reg.fill;
        end
        LST_OFS_HIST0: r_next.rdata[27:0] = r_reg.hist[0];
        LST_OFS_HIST1: r_next.rdata[27:0] = r_reg.hist[1];
        LST_OFS_HIST2: r_next.rdata[27:0] = r_reg.hist[2];
        LST_OFS_HIST3: r_next.rdata[27:0] = r_reg.hist[3];
        default: r_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Data line fixed low; only the enable ever moves
  assign alert_out = 1'b0; // [R10]
  assign alert_oe_n = r_reg.oe_n;
  assign meas_start = r_reg.start;
  assign meas_range_reset = (r_reg.st == LST_ST_RANGE);
  // Quick wake and continuous mode keep the front end up
  assign meas_powered = (r_reg.st != LST_ST_IDLE) | r_reg.quick_wake |
                        (r_reg.op_mode == LST_MODE_CONT); // [R7]

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Limits wake wide open so no result faults after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0; // [R23]
      r_reg.st <= LST_ST_IDLE;
      r_reg.thr_hi <= LST_THR_HI_RST;
      r_reg.thr_lo <= LST_THR_LO_RST;
      r_reg.oe_n <= 1'b1;
      r_reg.sync <= 3'h7;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule // lst_trigger_alert
`default_nettype wire

// ===== tb/lst_trigger_alert_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module lst_ta_monitor
  import lst_pkg::*;
#(
  parameter int RANGE_RST_CYC = 20,
  parameter int PULSE_CYC = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic alert_out,
  input wire logic alert_oe_n,
  input wire logic meas_start,
  input wire logic meas_range_reset,
  input wire logic meas_done
);
  // ---------------------------------------------------------------
  // Control shadow and run-length counters
  // ---------------------------------------------------------------
  logic [9:2] cfg_reg;
  logic busy_reg;
  int low_reg;
  int rr_reg;
  logic wr_ctrl;
  assign wr_ctrl = psel && penable && pwrite && pready && paddr == LST_OFS_CTRL;
  // Mode bits are left out: the block clears them by itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= '0;
      busy_reg <= 1'b0;
      low_reg <= 0;
      rr_reg <= 0;
    end else begin
      if (wr_ctrl) begin
        cfg_reg <= pwdata[9:2];
      end
      busy_reg <= (busy_reg || meas_start || meas_range_reset) && !meas_done;
      low_reg <= alert_oe_n ? 0 : low_reg + 1;
      rr_reg <= meas_range_reset ? rr_reg + 1 : 0;
    end
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_pulse_begin;
    ##2 !alert_oe_n;
  endsequence
  sequence s_range_over;
    $fell(meas_range_reset);
  endsequence

  open_drain_a: assert property (alert_out == 1'b0)
    else $error("alert data pin not held low");
  start_pulse_a: assert property (meas_start |=> !meas_start)
    else $error("start longer than one cycle");
  reg_trig_a: assert property (wr_ctrl && pwdata[1:0] == 2'h2 && !busy_reg |=> meas_start)
    else $error("regular trigger did not start");
  forced_trig_a: assert property (wr_ctrl && pwdata[1:0] == 2'h1 && !busy_reg |=> meas_range_reset)
    else $error("forced trigger skipped range reset");
  range_len_a: assert property (s_range_over |-> rr_reg == RANGE_RST_CYC)
    else $error("range reset length wrong");
  range_start_a: assert property (s_range_over |-> ##[0:1] meas_start)
    else $error("no start after range reset");
  input_quiet_a: assert property (!cfg_reg[3] && !$past(cfg_reg[3]) |-> alert_oe_n)
    else $error("pin pulled while used as input");
  pulse_start_a: assert property (meas_done && cfg_reg[3] && !cfg_reg[4] && cfg_reg[7:6] == 2'h1
    |-> s_pulse_begin)
    else $error("no pulse after conversion");
  pulse_width_a: assert property ($rose(alert_oe_n) && cfg_reg[7:6] == 2'h1 && cfg_reg[3] && !cfg_reg[4]
    |-> low_reg == PULSE_CYC)
    else $error("pulse width wrong");
endmodule // lst_ta_monitor

bind lst_trigger_alert lst_ta_monitor #(.RANGE_RST_CYC(RANGE_RST_CYC), .PULSE_CYC(PULSE_CYC)) u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .alert_out(alert_out), .alert_oe_n(alert_oe_n),
  .meas_start(meas_start), .meas_range_reset(meas_range_reset), .meas_done(meas_done));
`default_nettype wire

// ===== tb/lst_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module lst_engine_model #(
  parameter int DLY = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic meas_start,
  input wire logic [27:0] next_res,
  output logic meas_done,
  output logic [27:0] meas_result
);
  int cnt;
  logic [27:0] last_q;
  // Fixed-length conversion; result valid only with the done pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      meas_done <= 1'b0;
      last_q <= '0;
    end else begin
      meas_done <= (cnt == 1);
      if (meas_start) begin
        cnt <= DLY;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
      if (cnt == 1) begin
        last_q <= next_res;
      end
    end
  end
  // Stale code is inverted so a late sample cannot pass by luck
  assign meas_result = meas_done ? last_q : ~last_q;
endmodule // lst_engine_model
`default_nettype wire

// ===== tb/lst_trigger_alert_test.sv
`timescale 1ns/1ps
`default_nettype none
module lst_trigger_alert_test;
  import lst_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic host_n = 1'b1;
  logic oe_q = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, cfg;
  logic pready, pslverr, alert_out, alert_oe_n, er, meas_start, meas_range_reset, meas_powered, meas_done;
  logic [27:0] meas_result;
  logic [27:0] res = 28'h0;
  int error_cnt = 0;
  int check_count = 0;
  int starts = 0;
  int pulses = 0;
  int s0, p0;
  // Open-drain line with pull-up: host and device only pull low
  wire alert_pin = host_n & (alert_oe_n | alert_out);

  lst_trigger_alert #(.RANGE_RST_CYC(20), .PULSE_CYC(8)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .alert_in(alert_pin), .alert_out(alert_out), .alert_oe_n(alert_oe_n), .meas_start(meas_start),
    .meas_range_reset(meas_range_reset), .meas_powered(meas_powered), .meas_done(meas_done),
    .meas_result(meas_result));
  lst_engine_model #(.DLY(10)) eng (.pclk(pclk), .presetn(presetn), .meas_start(meas_start),
    .next_res(res), .meas_done(meas_done), .meas_result(meas_result));

  initial begin
    forever #10 pclk = ~pclk;
  end
  // Starts and pin pulses seen, for event counts
  always @(posedge pclk) begin
    starts <= starts + int'(meas_start);
    if (oe_q && !alert_oe_n) begin
      pulses <= pulses + 1;
    end
    oe_q <= alert_oe_n;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("Checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) begin
      error_cnt++;
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (meas_done !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 2000) begin
      error_cnt++;
      end_sim();
    end
    repeat (4) @(posedge pclk);
  endtask
  task automatic conv(input logic [27:0] r, input logic [1:0] m);
    res <= r;
    apb(1'b1, LST_OFS_CTRL, cfg | 32'(m));
    wait_done();
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, LST_OFS_THR_HI, 32'h0);
    chk(rd, 32'h0fffffff);
    apb(1'b0, LST_OFS_FLAGS, 32'h0);
    chk(rd & 32'h3, 32'h0);
    chk(alert_oe_n, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    chk({rd[30:0], er}, 32'h1);
  endtask
  task automatic t_trig(input logic [1:0] m);
    cfg = 32'h48;
    s0 = starts;
    p0 = pulses;
    res <= 28'h0000123;
    apb(1'b1, LST_OFS_CTRL, cfg | 32'(m));
    // Second trigger lands mid-conversion (mid range reset in forced mode) and must be dropped
    apb(1'b1, LST_OFS_CTRL, cfg | 32'(m));
    wait_done();
    chk(starts - s0, 32'h1);
    chk(pulses - p0, 32'h1);
    apb(1'b0, LST_OFS_CTRL, 32'h0);
    chk(rd[1:0], 32'h0);
    chk(meas_powered, 32'h0);
  endtask
  task automatic t_quick_wake();
    apb(1'b1, LST_OFS_CTRL, 32'h4c);
    @(negedge pclk);
    chk(meas_powered, 32'h1);
  endtask
  task automatic t_pin();
    cfg = 32'h0;
    apb(1'b1, LST_OFS_CTRL, cfg);
    s0 = starts;
    p0 = pulses;
    res <= 28'h0abcdef;
    @(posedge pclk);
    host_n <= 1'b0;
    repeat (4) @(posedge pclk);
    host_n <= 1'b1;
    // No completion sign: host waits out the conversion itself
    repeat (30) @(posedge pclk);
    chk(starts - s0, 32'h1);
    chk(pulses - p0, 32'h0);
    apb(1'b0, LST_OFS_HIST0, 32'h0);
    chk(rd, 32'h0abcdef);
  endtask
  task automatic t_hyst();
    logic [27:0] rv[4] = '{28'd200, 28'd75, 28'd10, 28'd200};
    logic [31:0] cv[4] = '{32'h08, 32'h08, 32'h08, 32'h48};
    logic [1:0] fv[4] = '{2'h1, 2'h1, 2'h2, 2'h1};
    logic ov[4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    apb(1'b1, LST_OFS_THR_HI, 32'd100);
    apb(1'b1, LST_OFS_THR_LO, 32'd50);
    for (int i = 0; i < 4; i++) begin
      cfg = cv[i];
      conv(rv[i], 2'h2);
      apb(1'b0, LST_OFS_FLAGS, 32'h0);
      chk(rd[1:0], fv[i]);
      // Let a completion pulse run out before judging the level
      repeat (8) @(negedge pclk);
      chk(alert_oe_n, ov[i]);
    end
  endtask
  task automatic t_latch();
    apb(1'b1, LST_OFS_THR_HI, 32'd100);
    cfg = 32'h128;
    conv(28'd200, 2'h2);
    @(negedge pclk);
    chk(alert_oe_n, 32'h1);
    conv(28'd200, 2'h2);
    @(negedge pclk);
    chk(alert_oe_n, 32'h0);
    apb(1'b0, LST_OFS_FLAGS, 32'h0);
    chk(rd[1:0], 32'h1);
    apb(1'b0, LST_OFS_FLAGS, 32'h0);
    chk(rd[1:0], 32'h0);
    @(negedge pclk);
    chk(alert_oe_n, 32'h1);
  endtask
  task automatic t_full();
    cfg = 32'hc8;
    p0 = pulses;
    for (int i = 0; i < 4; i++) begin
      conv(28'd75, 2'h2);
    end
    chk(pulses - p0, 32'h1);
    s0 = starts;
    conv(28'd75, 2'h1);
    chk(starts - s0, 32'h1);
    // Active-high: idle line is pulled low
    apb(1'b1, LST_OFS_CTRL, 32'h58);
    repeat (2) @(negedge pclk);
    chk(alert_oe_n, 32'h0);
  endtask
  task automatic t_cont();
    cfg = 32'h48;
    s0 = starts;
    p0 = pulses;
    apb(1'b1, LST_OFS_CTRL, cfg | 32'h3);
    // Two back-to-back results; the third start is already out
    wait_done();
    wait_done();
    chk(starts - s0, 32'h3);
    chk(pulses - p0, 32'h2);
  endtask

  initial begin
    do_reset();
    t_reset();
    t_trig(2'h2);
    t_trig(2'h1);
    t_quick_wake();
    t_pin();
    t_hyst();
    do_reset();
    t_latch();
    t_full();
    do_reset();
    t_cont();
    end_sim();
  end
endmodule // lst_trigger_alert_test
`default_nettype wire
